// ===== rtl/smrac_defines.vh
/*
 * Constants for the SMM RAM window access control block: register offset,
 * field positions, reset value and the compatible window bounds.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SMRAC_DEFINES_VH
`define SMRAC_DEFINES_VH

// =====================================================================
// Register map
// =====================================================================
`define SMRAC_CTRL_OFFSET 8'h9D
`define SMRAC_CTRL_RESET 8'h02
`define SMRAC_EXT_RESET 4'h0

// Field positions of the control register
`define SMRAC_BIT_OPEN 6
`define SMRAC_BIT_CLOSED 5
`define SMRAC_BIT_LOCK 4
`define SMRAC_BIT_GEN 3
`define SMRAC_BASE_SEG 3'h2

// =====================================================================
// Compatible SMM window, 128 KB from A0000h to BFFFFh
// =====================================================================
`define SMRAC_WIN_LO 32'h000A0000
`define SMRAC_WIN_HI 32'h000BFFFF

`endif

// ===== rtl/smrac_top.v
/*
 * SMM RAM window access control: the 8-bit control register at config
 * offset 9Dh and the route decision for host accesses into A0000h-BFFFFh.
 *
 * Control register fields:
 *   bit 7    reserved, reads zero
 *   bit 6    open: window visible outside SMM until locked
 *   bit 5    closed: data references kept off SMM DRAM unless open is set
 *   bit 4    locked: sticky until reset, freezes open and global enable, not closed
 *   bit 3    global enable: gates every other control
 *   bits 2:0 base segment, fixed at 010
 *
 * Each host strobe inside the window gets one route pulse a clock later,
 * to DRAM or to the hub, never both. Strobes outside the window give none.
 * The extended settings arrive as levels from the neighbouring register;
 * this block freezes them on lock and gates the two enables with global enable.
 *
 * Assumes config reads and writes and host cycles come from logic on
 * i_clk; one config access and one host cycle per clock at most.
 * Assumes i_rst is a full reset, the only way to drop the lock.
 */
`timescale 1ns/1ps
`include "smrac_defines.vh"

module smrac_top
(
    input wire i_clk,
    input wire i_rst,
    // Configuration access port
    input wire i_cfg_wr,
    input wire i_cfg_rd,
    input wire [7:0] i_cfg_addr,
    input wire [7:0] i_cfg_wdata,
    output reg [7:0] o_cfg_rdata,
    output reg o_cfg_rvalid,
    // Extended SYSTEM_MANAGEMENT_RAM_CONTROL settings from the neighbouring register
    input wire i_high_system_management_ram_control_enable,
    input wire [1:0] i_top_segment_size,
    input wire i_top_segment_enable,
    // Host cycle request
    input wire i_host_address_strobe,
    input wire [31:0] i_host_addr,
    input wire i_host_smm,
    input wire i_host_code,
    // Route decision
    output reg o_route_valid,
    output reg o_route_dram,
    output reg o_route_hub,
    // Lock state and qualified extended settings
    output reg o_smm_space_locked,
    output reg o_high_system_management_ram_control_active,
    output reg o_top_segment_active,
    output reg [1:0] o_top_segment_size
);

    // =================================================================
    // Control register state
    // =================================================================
    reg open_reg;
    reg closed_reg;
    reg lock_reg;
    reg gen_reg;
    reg open_next;
    reg closed_next;
    reg lock_next;
    reg gen_next;
    reg [3:0] ext_reg;

    wire cfg_hit;
    wire ctrl_wr;
    wire lock_take;
    wire [7:0] ctrl_value;

    // =================================================================
    // Decode helpers
    // =================================================================

    // Read image of the control register from its stored fields
    function [7:0] smrac_ctrl_image;
        input open;
        input closed;
        input lock;
        input gen;
        begin
            smrac_ctrl_image = {1'b0, open, closed, lock, gen,
                                `SMRAC_BASE_SEG};
        end
    endfunction

    // Lock is taken only from an unlocked state with global enable on
    function smrac_lock_take;
        input wr;
        input [7:0] wdata;
        input gen;
        input lock;
        begin
            smrac_lock_take = wr && !lock && gen &&
                              wdata[`SMRAC_BIT_LOCK];
        end
    endfunction

    // Read data: the image on a hit, zero for any other offset
    function [7:0] smrac_read_mux;
        input rd;
        input hit;
        input [7:0] image;
        begin
            smrac_read_mux = (rd && hit) ? image : 8'h00;
        end
    endfunction

    // Extended enables only count while global enable is on
    function smrac_qualify;
        input gen;
        input en;
        begin
            smrac_qualify = gen & en;
        end
    endfunction

    // True when a host address falls inside the compatible window
    function smrac_in_window;
        input [31:0] addr;
        begin
            smrac_in_window = (addr >= `SMRAC_WIN_LO) &&
                              (addr <= `SMRAC_WIN_HI);
        end
    endfunction

    // DRAM visibility for one host cycle inside the compatible window
    function smrac_dram_ok;
        input gen;
        input open;
        input closed;
        input lock;
        input smm;
        input code;
        begin
            smrac_dram_ok = 1'b0;
            // Every control is inert while global enable is off
            if (gen)
            begin
                if (open && !lock)
                begin
                    // Set-up path for loading the SMM handler
                    smrac_dram_ok = 1'b1;
                end
                else if (smm)
                begin
                    // Data references stop here once closed
                    smrac_dram_ok = code || !closed;
                end
            end
        end
    endfunction

    // =================================================================
    // Control register write path
    // =================================================================
    assign cfg_hit = (i_cfg_addr == `SMRAC_CTRL_OFFSET);
    assign ctrl_wr = i_cfg_wr && cfg_hit;
    assign lock_take = smrac_lock_take(ctrl_wr, i_cfg_wdata, gen_reg,
                                       lock_reg);

    // Register image; bit 7 reads zero, base segment is fixed
    assign ctrl_value = smrac_ctrl_image(open_reg, closed_reg, lock_reg,
                                         gen_reg);

    // Write handling with lock protection
    always @*
    begin
        open_next = open_reg;
        closed_next = closed_reg;
        lock_next = lock_reg;
        gen_next = gen_reg;
        if (ctrl_wr)
        begin
            // Closed stays writable after lock
            closed_next = i_cfg_wdata[`SMRAC_BIT_CLOSED];
            if (!lock_reg)
            begin
                gen_next = i_cfg_wdata[`SMRAC_BIT_GEN];
                open_next = i_cfg_wdata[`SMRAC_BIT_OPEN];
            end
            // Taking lock always drops open in the same write
            if (lock_take)
            begin
                lock_next = 1'b1;
                open_next = 1'b0;
            end
        end
    end

    // Register update; only reset clears lock
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            open_reg <= 1'b0;
            closed_reg <= 1'b0;
            lock_reg <= 1'b0;
            gen_reg <= 1'b0;
        end
        else
        begin
            open_reg <= open_next;
            closed_reg <= closed_next;
            lock_reg <= lock_next;
            gen_reg <= gen_next;
        end
    end

    // =================================================================
    // Config read port
    // =================================================================
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_cfg_rdata <= 8'h00;
            o_cfg_rvalid <= 1'b0;
        end
        else
        begin
            o_cfg_rvalid <= i_cfg_rd;
            o_cfg_rdata <= smrac_read_mux(i_cfg_rd, cfg_hit, ctrl_value);
        end
    end

    // =================================================================
    // Extended settings: frozen on lock, enables qualified by global enable
    // =================================================================
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ext_reg <= `SMRAC_EXT_RESET;
        end
        else if (!lock_reg)
        begin
            ext_reg <= {i_high_system_management_ram_control_enable, i_top_segment_size,
                        i_top_segment_enable};
        end
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_high_system_management_ram_control_active <= 1'b0;
            o_top_segment_active <= 1'b0;
            o_top_segment_size <= 2'h0;
            o_smm_space_locked <= 1'b0;
        end
        else
        begin
            o_high_system_management_ram_control_active <= smrac_qualify(gen_reg, ext_reg[3]);
            o_top_segment_active <= smrac_qualify(gen_reg, ext_reg[0]);
            o_top_segment_size <= ext_reg[2:1];
            o_smm_space_locked <= lock_reg;
        end
    end

    // =================================================================
    // Host routing for the compatible window
    // =================================================================
    wire in_window;
    reg dram_ok;

    assign in_window = smrac_in_window(i_host_addr);

    // Access check; closed only covers this compatible window
    always @*
    begin
        dram_ok = smrac_dram_ok(gen_reg, open_reg, closed_reg, lock_reg,
                                i_host_smm, i_host_code);
    end

    // One route result per in-window strobe, one cycle later
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_route_valid <= 1'b0;
            o_route_dram <= 1'b0;
            o_route_hub <= 1'b0;
        end
        else
        begin
            o_route_valid <= i_host_address_strobe & in_window;
            o_route_dram <= i_host_address_strobe & in_window & dram_ok;
            o_route_hub <= i_host_address_strobe & in_window
                           & !dram_ok;
        end
    end

endmodule // smrac_top

// ===== test/smrac_assertions.sv
/* Port checker for smrac_top.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
module smrac_assertions
(
    input wire i_clk,
    input wire i_rst,
    input wire i_cfg_rd,
    input wire [7:0] i_cfg_addr,
    input wire [7:0] o_cfg_rdata,
    input wire o_cfg_rvalid,
    input wire i_host_address_strobe,
    input wire [31:0] i_host_addr,
    input wire i_host_smm,
    input wire o_route_valid,
    input wire o_route_dram,
    input wire o_route_hub,
    input wire o_smm_space_locked
);
    // ================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire win = i_host_addr >= 32'h000A0000 && i_host_addr <= 32'h000BFFFF;
    sequence s_hit;
        i_host_address_strobe && win;
    endsequence
    sequence s_rdc;
        i_cfg_rd && i_cfg_addr == 8'h9D;
    endsequence
    AST_HIT: assert property (s_hit |=> o_route_valid)
        else $error("window hit gave no route");
    AST_MISS: assert property (i_host_address_strobe && !win |=>
        !o_route_valid) else $error("route outside window");
    AST_ONE: assert property (o_route_valid |-> o_route_dram ^ o_route_hub)
        else $error("route not one-hot");
    AST_RVALID: assert property (i_cfg_rd |=> o_cfg_rvalid)
        else $error("read gave no valid");
    AST_BASE: assert property (s_rdc |=> o_cfg_rdata[2:0] == 3'h2)
        else $error("base segment wrong");
    AST_RSVD: assert property (s_rdc |=> !o_cfg_rdata[7])
        else $error("reserved bit set");
    AST_LOCKED: assert property (s_hit and !i_host_smm
        and o_smm_space_locked |=> o_route_hub)
        else $error("locked open reached DRAM");
    AST_STICKY: assert property (o_smm_space_locked |=> o_smm_space_locked)
        else $error("lock dropped without reset");
endmodule // smrac_assertions

// ===== test/smrac_host_model.sv
/* Host cycle source for smrac_top.
   Assumes the bench samples routes at falling edges. */
`timescale 1ns/1ps
module smrac_host_model
(
    input wire i_clk,
    output reg o_strobe = 1'b0,
    output reg [31:0] o_addr = 32'h0,
    output reg o_smm = 1'b0,
    output reg o_code = 1'b0
);
    // ================================================
    // One strobe cycle on the host path only, lines scrambled after
    task cycle(input logic [31:0] a, input logic s, input logic c);
        @(negedge i_clk);
        o_strobe = 1'b1;
        o_addr = a;
        o_smm = s;
        o_code = c;
        @(negedge i_clk);
        o_strobe = 1'b0;
        o_addr = ~a;
        o_smm = ~s;
        o_code = ~c;
    endtask
endmodule // smrac_host_model

// ===== test/tb_smrac_top.sv
/* Self-checking bench for smrac_top.
   Assumes the rtl files, host model and checker. */
`timescale 1ns/1ps
module tb_smrac_top;
    reg i_clk = 1'b0, i_rst = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
    reg [7:0] i_cfg_addr = 8'h9D, i_cfg_wdata = 8'h00;
    reg hse = 1'b1, tse = 1'b1;
    reg [1:0] tsz = 2'h1;
    wire [7:0] rdata;
    wire rv, vld, dram, hub, lck, hact, tact, hs, hsmm, hcode;
    wire [1:0] osz;
    wire [31:0] ha;
    integer n_fail = 0, checked = 0, k;
    // Rows: control byte, smm, code, dram, hub; open and closed never both
    logic [11:0] rows [0:5] = '{12'h409, 12'h08A, 12'h081, 12'h482,
        12'h289, 12'h28E};
    smrac_top u_smrac_top
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr),
        .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rv),
        .i_high_system_management_ram_control_enable(hse), .i_top_segment_size(tsz),
        .i_top_segment_enable(tse), .i_host_address_strobe(hs),
        .i_host_addr(ha), .i_host_smm(hsmm), .i_host_code(hcode),
        .o_route_valid(vld), .o_route_dram(dram), .o_route_hub(hub),
        .o_smm_space_locked(lck), .o_high_system_management_ram_control_active(hact),
        .o_top_segment_active(tact), .o_top_segment_size(osz)
    );
    smrac_host_model u_smrac_host_model
    (
        .i_clk(i_clk), .o_strobe(hs), .o_addr(ha), .o_smm(hsmm),
        .o_code(hcode)
    );
    // ================================================
    // Clock and helpers
    always #2.5 i_clk = ~i_clk;
    task chk(input [7:0] seen, input [7:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task wr(input [7:0] d);
        @(negedge i_clk);
        i_cfg_wr = 1'b1;
        i_cfg_addr = 8'h9D;
        i_cfg_wdata = d;
        @(negedge i_clk);
        i_cfg_wr = 1'b0;
    endtask
    task rd(input [7:0] a);
        @(negedge i_clk);
        i_cfg_rd = 1'b1;
        i_cfg_addr = a;
        @(negedge i_clk);
        i_cfg_rd = 1'b0;
    endtask
    task route(input [31:0] a, input s, input c, input [2:0] e);
        u_smrac_host_model.cycle(a, s, c);
        chk({5'h0, vld, dram, hub}, {5'h0, e});
    endtask
    // ================================================
    // Main sequence
    initial
    begin
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        rd(8'h9D);
        chk(rdata, 8'h02);
        chk({7'h0, rv}, 8'h01);
        rd(8'h9E);
        chk(rdata, 8'h00);
        for (k = 0; k < 6; k = k + 1)
        begin
            wr(rows[k][11:4]);
            route(32'h000A0000, rows[k][3], rows[k][2], {1'b1, rows[k][1:0]});
            chk({7'h0, hact}, {7'h0, rows[k][7]});
            chk({7'h0, tact}, {7'h0, rows[k][7]});
        end
        wr(8'hA7);
        rd(8'h9D);
        chk(rdata, 8'h22);
        wr(8'h08);
        route(32'h000BFFFF, 1'b1, 1'b0, 3'h6);
        route(32'h000C0000, 1'b1, 1'b0, 3'h0);
        route(32'h0009FFFF, 1'b1, 1'b0, 3'h0);
        wr(8'h58);
        rd(8'h9D);
        chk(rdata, 8'h1A);
        hse = 1'b0;
        tsz = 2'h3;
        wr(8'h00);
        rd(8'h9D);
        chk(rdata, 8'h1A);
        chk({5'h0, hact, osz}, 8'h05);
        route(32'h000A0000, 1'b0, 1'b0, 3'h5);
        i_rst = 1'b1;
        @(negedge i_clk);
        i_rst = 1'b0;
        rd(8'h9D);
        chk({rdata[7:1], lck}, 8'h02);
        summarize;
    end
endmodule // tb_smrac_top
bind smrac_top smrac_assertions u_smrac_assertions (.*);
